/* File: tx_fa_pkg.sv */
package tx_fa_pkg;

  // Geometry of the transmit side.
  localparam int NUM_CH = 4;
  localparam int FIFO_WORDS = 256;
  localparam int CNT_W = 9;
  localparam int CELL_WORDS = 13;
  localparam int ADDR_W = 3;
  localparam int AXI_AW = 8;

  // Register byte offset and address groups (address bits 7:4).
  localparam logic [7:0] GLOBAL_CFG_OFS = 8'h00;
  localparam logic [3:0] GRP_GLOBAL = 4'h0;
  localparam logic [3:0] GRP_CHAN_CFG = 4'h1;
  localparam logic [3:0] GRP_LOW_MARK = 4'h2;
  localparam logic [3:0] GRP_HIGH_MARK = 4'h3;
  localparam logic [3:0] GRP_STATUS = 4'h4;

  // Field positions.
  localparam int CELL_MODE_BIT = 0;
  localparam int DIRECT_BIT = 1;
  localparam int DELAY_BIT = 2;
  localparam int BASE_LSB = 4;
  localparam int DROP_W = 6;
  localparam int FLAG_BIT = 16;

  // Legal payload byte positions for the drop point.
  localparam logic [5:0] DROP_MIN = 6'h09;
  localparam logic [5:0] DROP_MAX = 6'h30;

  // Reset values.
  localparam logic RST_CELL_MODE = 1'b1;
  localparam logic RST_DIRECT = 1'b1;
  localparam logic RST_DELAY = 1'b0;
  localparam logic [ADDR_W-1:0] RST_BASE = 3'h0;
  localparam logic [5:0] RST_DROP = 6'h30;
  localparam logic [CNT_W-1:0] RST_LOW_MARK = 9'h020;
  localparam logic [CNT_W-1:0] RST_HIGH_MARK = 9'h008;

  // Write and read responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic cell_mode;
    logic direct;
    logic delay;
    logic [ADDR_W-1:0] base;
    logic [NUM_CH-1:0][DROP_W-1:0] drop;
    logic [NUM_CH-1:0][CNT_W-1:0] low_mark;
    logic [NUM_CH-1:0][CNT_W-1:0] high_mark;
  } cfg_t;

  typedef struct packed {
    logic [NUM_CH-1:0] flag;
    logic [NUM_CH-1:0][CNT_W-1:0] free;
  } stat_t;

endpackage

/* File: cross_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Carries one word between the two clock domains.
interface cross_if #(
  parameter int W = 8
);
  logic [W-1:0] src_word;
  logic [W-1:0] dst_word;

  modport user (output src_word, input dst_word);
  modport sync (input src_word, output dst_word);
endinterface

`default_nettype wire

/* File: word_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Moves a slowly changing word across clocks with a toggle handshake.
module word_sync #(
  parameter int W = 8
) (
  // Source domain
  input wire logic src_clk,
  input wire logic src_rst_n,
  // Destination domain
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  // Word carrier
  cross_if.sync x
);

  logic [W-1:0] held_q, held_d;
  logic req_q, req_d;
  logic busy_q, busy_d;
  logic ack_s1_q, ack_s2_q;
  logic req_s1_q, req_s2_q, req_s3_q;
  logic [W-1:0] out_q, out_d;

  ////////////////////////////////////////////////////////////////////////////
  // The held word stays frozen until the far side has acknowledged it.
  always_comb begin
    held_d = held_q;
    req_d = req_q;
    busy_d = busy_q;
    if (busy_q && (ack_s2_q == req_q)) begin
      busy_d = 1'b0;
    end else if (!busy_q && (x.src_word != held_q)) begin
      held_d = x.src_word;
      req_d = ~req_q;
      busy_d = 1'b1;
    end
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      held_q <= '0;
      req_q <= 1'b0;
      busy_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      held_q <= held_d;
      req_q <= req_d;
      busy_q <= busy_d;
      ack_s1_q <= req_s3_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    out_d = out_q;
    if (req_s2_q != req_s3_q) begin
      out_d = held_q;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      out_q <= '0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      out_q <= out_d;
    end
  end

  assign x.dst_word = out_q;

endmodule

`default_nettype wire

/* File: tx_fifo_space_flag.sv */
`timescale 1ns/1ps
`default_nettype none

module tx_fifo_space_flag
  import tx_fa_pkg::*;
#(
  parameter int FIFO_DEPTH = tx_fa_pkg::FIFO_WORDS
) (
  // Register clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [tx_fa_pkg::AXI_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [tx_fa_pkg::AXI_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Transmit link clock
  input wire logic tx_clk,
  // Transmit FIFO events, one bit per channel, on tx_clk
  input wire logic [tx_fa_pkg::NUM_CH-1:0] fifo_write,
  input wire logic [tx_fa_pkg::NUM_CH-1:0] fifo_sop,
  input wire logic [tx_fa_pkg::NUM_CH-1:0] fifo_drain,
  // Transmit polling address
  input wire logic [tx_fa_pkg::ADDR_W-1:0] tx_addr,
  // Frame-available pins
  output logic [tx_fa_pkg::NUM_CH-1:0] tx_frame_available,
  output logic tx_frame_available_oe
);

  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(FIFO_DEPTH);
  localparam logic [CNT_W-1:0] CELL_C = CNT_W'(CELL_WORDS);
  localparam logic [CNT_W-1:0] TWO_CELL_C = CNT_W'(2 * CELL_WORDS);
  localparam logic [3:0] LAST_IDX_C = 4'(CELL_WORDS - 1);

  // Word of the cell holding payload byte pos; word 0 carries the header.
  // The writer gets its warning as many words early as the position leaves.
  function automatic logic [3:0] drop_word(input logic [DROP_W-1:0] pos);
    logic [DROP_W-1:0] off;
    off = pos - 6'h01;
    return 4'(off[DROP_W-1:2]) + 4'h1;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register side, on aclk.

  cross_if #(.W($bits(cfg_t))) cfg_x ();
  cross_if #(.W($bits(stat_t))) stat_x ();

  cfg_t cfg_q, cfg_d;
  stat_t stat_seen;
  logic aw_have_q, aw_have_d;
  logic [AXI_AW-1:0] aw_addr_q, aw_addr_d;
  logic w_have_q, w_have_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  assign stat_seen = stat_t'(stat_x.dst_word);
  assign cfg_x.src_word = cfg_q;

  always_comb begin
    logic [3:0] grp;
    logic [1:0] ch;
    logic [31:0] cur;
    logic [31:0] nv;
    grp = 4'h0;
    ch = 2'h0;
    cur = 32'h0;
    nv = 32'h0;
    cfg_d = cfg_q;
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    // Both halves of a write in hand: apply it and answer once.
    if (aw_have_q && w_have_q && !bvalid_q) begin
      grp = aw_addr_q[7:4];
      ch = aw_addr_q[3:2];
      bresp_d = RESP_OKAY;
      case (grp)
        GRP_GLOBAL: begin
          if (aw_addr_q[3:2] == GLOBAL_CFG_OFS[3:2]) begin
            cur = '0;
            cur[CELL_MODE_BIT] = cfg_q.cell_mode;
            cur[DIRECT_BIT] = cfg_q.direct;
            cur[DELAY_BIT] = cfg_q.delay;
            cur[BASE_LSB +: ADDR_W] = cfg_q.base;
            nv = merge_strb(cur, w_data_q, w_strb_q);
            cfg_d.cell_mode = nv[CELL_MODE_BIT];
            cfg_d.direct = nv[DIRECT_BIT];
            cfg_d.delay = nv[DELAY_BIT];
            cfg_d.base = nv[BASE_LSB +: ADDR_W];
          end else begin
            bresp_d = RESP_SLVERR;
          end
        end
        GRP_CHAN_CFG: begin
          nv = merge_strb(32'(cfg_q.drop[ch]), w_data_q, w_strb_q);
          // Drop range check
          // out-of-range positions are refused and the old value kept.
          if (nv[DROP_W-1:0] >= DROP_MIN && nv[DROP_W-1:0] <= DROP_MAX) begin
            cfg_d.drop[ch] = nv[DROP_W-1:0];
          end else begin
            bresp_d = RESP_SLVERR;
          end
        end
        GRP_LOW_MARK: begin
          nv = merge_strb(32'(cfg_q.low_mark[ch]), w_data_q, w_strb_q);
          cfg_d.low_mark[ch] = nv[CNT_W-1:0];
        end
        GRP_HIGH_MARK: begin
          nv = merge_strb(32'(cfg_q.high_mark[ch]), w_data_q, w_strb_q);
          cfg_d.high_mark[ch] = nv[CNT_W-1:0];
        end
        default: begin
          bresp_d = RESP_SLVERR;
        end
      endcase
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready_q) begin
      grp = araddr[7:4];
      ch = araddr[3:2];
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0;
      case (grp)
        GRP_GLOBAL: begin
          if (araddr[3:2] == GLOBAL_CFG_OFS[3:2]) begin
            rdata_d[CELL_MODE_BIT] = cfg_q.cell_mode;
            rdata_d[DIRECT_BIT] = cfg_q.direct;
            rdata_d[DELAY_BIT] = cfg_q.delay;
            rdata_d[BASE_LSB +: ADDR_W] = cfg_q.base;
          end else begin
            rresp_d = RESP_SLVERR;
          end
        end
        GRP_CHAN_CFG: rdata_d[DROP_W-1:0] = cfg_q.drop[ch];
        GRP_LOW_MARK: rdata_d[CNT_W-1:0] = cfg_q.low_mark[ch];
        GRP_HIGH_MARK: rdata_d[CNT_W-1:0] = cfg_q.high_mark[ch];
        GRP_STATUS: begin
          rdata_d[CNT_W-1:0] = stat_seen.free[ch];
          rdata_d[FLAG_BIT] = stat_seen.flag[ch];
        end
        default: rresp_d = RESP_SLVERR;
      endcase
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q.cell_mode <= RST_CELL_MODE;
      cfg_q.direct <= RST_DIRECT;
      cfg_q.delay <= RST_DELAY;
      cfg_q.base <= RST_BASE;
      cfg_q.drop <= {NUM_CH{RST_DROP}};
      cfg_q.low_mark <= {NUM_CH{RST_LOW_MARK}};
      cfg_q.high_mark <= {NUM_CH{RST_HIGH_MARK}};
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end else begin
      cfg_q <= cfg_d;
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings. Settings are quasi-static, so a handshake per change suffices.

  logic tx_rst_s1_q, tx_rst_s2_q;

  always_ff @(posedge tx_clk) begin
    tx_rst_s1_q <= aresetn;
    tx_rst_s2_q <= tx_rst_s1_q;
  end

  word_sync #(.W($bits(cfg_t))) u_cfg_sync (
    .src_clk(aclk),
    .src_rst_n(aresetn),
    .dst_clk(tx_clk),
    .dst_rst_n(tx_rst_s2_q),
    .x(cfg_x.sync)
  );

  word_sync #(.W($bits(stat_t))) u_stat_sync (
    .src_clk(tx_clk),
    .src_rst_n(tx_rst_s2_q),
    .dst_clk(aclk),
    .dst_rst_n(aresetn),
    .x(stat_x.sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link side, on tx_clk.

  cfg_t tx_cfg;
  logic [NUM_CH-1:0][CNT_W-1:0] free_q, free_d;
  logic [NUM_CH-1:0][3:0] idx_q, idx_d;
  logic [NUM_CH-1:0] in_cell_q, in_cell_d;
  logic [NUM_CH-1:0] last_q, last_d;
  logic [NUM_CH-1:0] held_q, held_d;
  logic [NUM_CH-1:0] flag_q, flag_d;
  logic match_q, match_d;
  logic oe_q, oe_d;

  assign tx_cfg = cfg_t'(cfg_x.dst_word);
  assign stat_x.src_word = {flag_q, free_q};

  always_comb begin
    logic wr;
    logic dr;
    logic [3:0] idx_now;
    logic last_now;
    logic hit;
    logic [CNT_W:0] need;
    wr = 1'b0;
    dr = 1'b0;
    idx_now = 4'h0;
    last_now = 1'b0;
    hit = 1'b0;
    need = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      // Writes into a full FIFO and drains of an empty one are ignored.
      wr = fifo_write[c] && (free_q[c] != '0);
      dr = fifo_drain[c] && (free_q[c] != DEPTH_C);
      free_d[c] = free_q[c] + CNT_W'(dr) - CNT_W'(wr);
      idx_d[c] = idx_q[c];
      in_cell_d[c] = in_cell_q[c];
      last_d[c] = last_q[c];
      held_d[c] = held_q[c];
      idx_now = fifo_sop[c] ? 4'h0 : idx_q[c];
      last_now = fifo_sop[c] ? (free_q[c] < TWO_CELL_C) : last_q[c];
      if (wr && tx_cfg.cell_mode) begin
        last_d[c] = last_now;
        if (idx_now == LAST_IDX_C) begin
          in_cell_d[c] = 1'b0;
          idx_d[c] = 4'h0;
          held_d[c] = 1'b0;
        end else begin
          in_cell_d[c] = 1'b1;
          idx_d[c] = idx_now + 4'h1;
        end
      end
      // Late drop
      // the flag falls on the edge that takes the selected payload word.
      // an early enough position leaves the writer four or more cycles.
      hit = wr && tx_cfg.cell_mode && last_now && (idx_now == drop_word(tx_cfg.drop[c]));
      if (hit && (idx_now != LAST_IDX_C)) begin
        held_d[c] = 1'b1;
      end
      need = {1'b0, CELL_C} + (in_cell_d[c] ? (CNT_W + 1)'(CELL_WORDS) - (CNT_W + 1)'(idx_d[c]) : '0);
      // Flag update
      // every flag is a tx_clk flip-flop, so it only moves on rising edges.
      if (tx_cfg.cell_mode) begin
        if (hit || held_d[c]) begin
          flag_d[c] = 1'b0;
        end else if (in_cell_d[c] && last_d[c]) begin
          flag_d[c] = 1'b1;
        end else begin
          // Cell handshake
          // high while a whole cell fits beyond the one being written.
          flag_d[c] = {1'b0, free_d[c]} >= need;
        end
      end else begin
        // Packet watermarks
        // full or below the nearly-full mark clears the flag.
        // at or above the nearly-empty mark sets it.
        // in between the flag keeps its value.
        if (free_d[c] == '0 || free_d[c] < tx_cfg.high_mark[c]) begin
          flag_d[c] = 1'b0;
        end else if (free_d[c] >= tx_cfg.low_mark[c]) begin
          flag_d[c] = 1'b1;
        end else begin
          flag_d[c] = flag_q[c];
        end
      end
    end
  end

  // Pin drive
  // direct status keeps the pins driven all the time.
  // polling drives all four one or two cycles after a base match.
  always_comb begin
    match_d = (tx_addr == tx_cfg.base);
    if (tx_cfg.direct) begin
      oe_d = 1'b1;
    end else if (tx_cfg.delay) begin
      oe_d = match_q;
    end else begin
      oe_d = match_d;
    end
  end

  always_ff @(posedge tx_clk) begin
    if (!tx_rst_s2_q) begin
      free_q <= {NUM_CH{DEPTH_C}};
      idx_q <= '0;
      in_cell_q <= '0;
      last_q <= '0;
      held_q <= '0;
      flag_q <= '0;
      match_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      free_q <= free_d;
      idx_q <= idx_d;
      in_cell_q <= in_cell_d;
      last_q <= last_d;
      held_q <= held_d;
      flag_q <= flag_d;
      match_q <= match_d;
      oe_q <= oe_d;
    end
  end

  assign tx_frame_available = flag_q;
  assign tx_frame_available_oe = oe_q;

endmodule

`default_nettype wire

/* File: tx_fifo_space_flag_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module tx_fifo_space_flag_asserts #(
  parameter int FIFO_DEPTH = tx_fa_pkg::FIFO_WORDS
) (
  // Register side
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Link side
  input wire logic tx_clk,
  input wire logic [tx_fa_pkg::NUM_CH-1:0] fifo_write,
  input wire logic [tx_fa_pkg::NUM_CH-1:0] fifo_drain,
  input wire logic [tx_fa_pkg::NUM_CH-1:0] tx_frame_available,
  input wire logic tx_frame_available_oe
);
  import tx_fa_pkg::*;

  logic [NUM_CH-1:0][CNT_W-1:0] free_q, free_d;
  logic [NUM_CH-1:0] full;
  logic [NUM_CH-1:0] mid_q;
  logic tx_rst_s1_q, tx_rst_s2_q;

  ////////////////////////////////////////////////////////////////////////////////
  // The link side leaves reset two link edges after the bus side, as the block does.
  always_ff @(posedge tx_clk) begin
    tx_rst_s1_q <= aresetn;
    tx_rst_s2_q <= tx_rst_s1_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mirror of the free words, so the checker knows when a FIFO is full.
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      full[c] = (free_q[c] == '0);
      free_d[c] = free_q[c];
      if (fifo_write[c] && !full[c]) free_d[c] = free_d[c] - CNT_W'(1);
      if (fifo_drain[c] && free_q[c] != CNT_W'(FIFO_DEPTH)) free_d[c] = free_d[c] + CNT_W'(1);
    end
  end

  always_ff @(posedge tx_clk) begin
    if (!tx_rst_s2_q) begin
      free_q <= {NUM_CH{CNT_W'(FIFO_DEPTH)}};
    end else begin
      free_q <= free_d;
    end
  end

  // Taken mid-cycle: a change away from the rising edge shows as a mismatch there.
  always_ff @(negedge tx_clk) begin
    mid_q <= tx_frame_available;
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence aw_take;
    awvalid && awready;
  endsequence

  sequence both_take;
    awvalid && awready && wvalid && wready;
  endsequence

  b_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped early");
  r_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp)) else $error("read data dropped early");
  aw_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_take |=> !awready [*2]) else $error("write address taken while busy");
  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    both_take |=> ##1 bvalid) else $error("write response late");
  read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready |-> ##[1:2] rvalid) else $error("read data late");
  slverr_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0) else $error("refused read returns data");
  flag_edge_a: assert property (@(posedge tx_clk) disable iff (!aresetn || !tx_rst_s2_q)
    tx_frame_available == mid_q) else $error("flag changed away from the rising edge");
  full_flag_a: assert property (@(posedge tx_clk) disable iff (!aresetn || !tx_rst_s2_q)
    tx_frame_available_oe |-> (full & tx_frame_available) == '0) else $error("flag high on a full FIFO");
endmodule

bind tx_fifo_space_flag tx_fifo_space_flag_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) chk_i (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .tx_clk(tx_clk), .fifo_write(fifo_write), .fifo_drain(fifo_drain),
  .tx_frame_available(tx_frame_available), .tx_frame_available_oe(tx_frame_available_oe));

`default_nettype wire

/* File: layer_model.sv */
`timescale 1ns/1ps
`default_nettype none

module layer_model (
  // Link clock
  input wire logic tx_clk,
  // Words toward the device
  output logic [tx_fa_pkg::NUM_CH-1:0] fifo_write,
  output logic [tx_fa_pkg::NUM_CH-1:0] fifo_sop,
  // Polling address
  output logic [tx_fa_pkg::ADDR_W-1:0] tx_addr
);
  import tx_fa_pkg::*;

  initial begin
    fifo_write = '0;
    fifo_sop = '0;
    tx_addr = '1;
  end

  // Back-to-back words; a start mark on every thirteenth keeps cells whole.
  task automatic burst(input int ch, input int n, input int start);
    for (int i = 0; i < n; i++) begin
      fifo_write <= NUM_CH'(1) << ch;
      fifo_sop <= ((start + i) % CELL_WORDS == 0) ? NUM_CH'(1) << ch : '0;
      @(posedge tx_clk);
    end
    fifo_write <= '0;
    fifo_sop <= '0;
  endtask

  task automatic poll(input logic [ADDR_W-1:0] a);
    tx_addr <= a;
    @(posedge tx_clk);
    tx_addr <= ~a;
  endtask
endmodule

`default_nettype wire

/* File: tb_tx_fifo_space_flag.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_tx_fifo_space_flag;
  import tx_fa_pkg::*;

  logic aclk, tx_clk;
  logic aresetn = 1'b0;
  logic [AXI_AW-1:0] awaddr = '0;
  logic [AXI_AW-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [NUM_CH-1:0] fifo_drain = '0;
  logic awready, wready, bvalid, arready, rvalid, tx_frame_available_oe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [NUM_CH-1:0] fifo_write, fifo_sop, tx_frame_available;
  logic [ADDR_W-1:0] tx_addr;
  int fails = 0;
  int num_checks = 0;

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    tx_clk = 1'b0;
    #1.3;
    forever #6 tx_clk = ~tx_clk;
  end

  tx_fifo_space_flag dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .tx_clk(tx_clk), .fifo_write(fifo_write), .fifo_sop(fifo_sop),
    .fifo_drain(fifo_drain), .tx_addr(tx_addr), .tx_frame_available(tx_frame_available),
    .tx_frame_available_oe(tx_frame_available_oe));

  layer_model lyr (.tx_clk(tx_clk), .fifo_write(fifo_write), .fifo_sop(fifo_sop), .tx_addr(tx_addr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic timed_out(input bit got);
    if (!got) begin
      fails++;
      finish_test();
    end
  endtask

  // The ready is raised late on purpose so that a held response is seen.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit got;
    got = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 100 && !got; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (n == 2) bready <= 1'b1;
      if (bvalid && bready) begin
        got = 1;
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
      end
    end
    timed_out(got);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit got;
    got = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 100 && !got; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (n == 2) rready <= 1'b1;
      if (rvalid && rready) begin
        got = 1;
        rready <= 1'b0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
      end
    end
    timed_out(got);
  endtask

  // Checks the pin enable together with one channel's flag, away from the edge.
  task automatic flag_is(input int ch, input logic e, input int w);
    repeat (w) @(posedge tx_clk);
    @(negedge tx_clk);
    chk({30'h0, tx_frame_available_oe, tx_frame_available[ch]}, {30'h0, 1'b1, e});
    @(posedge tx_clk);
  endtask

  task automatic drain(input int ch, input int n);
    for (int i = 0; i < n; i++) begin
      fifo_drain <= NUM_CH'(1) << ch;
      @(posedge tx_clk);
    end
    fifo_drain <= '0;
  endtask

  // Eighteen cells leave 22 free words, so the next cell takes the last slot.
  task automatic cell_last(input int ch, input int p);
    int dw;
    dw = 1 + (p - 1) / 4;
    lyr.burst(ch, 18 * CELL_WORDS, 0);
    flag_is(ch, 1'b1, 2);
    for (int k = 0; k < CELL_WORDS; k++) begin
      lyr.burst(ch, 1, k);
      flag_is(ch, k < dw, 0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(8'h00, 32'h3, RESP_OKAY);
    axi_read(8'h10, 32'h30, RESP_OKAY);
    axi_read(8'h24, 32'h20, RESP_OKAY);
    axi_read(8'h3c, 32'h8, RESP_OKAY);
    axi_read(8'h50, 32'h0, RESP_SLVERR);
    axi_write(8'h0c, 32'h1, RESP_SLVERR);
    axi_write(8'h40, 32'h0, RESP_SLVERR);
    axi_write(8'h10, 32'h8, RESP_SLVERR);
    axi_write(8'h10, 32'h31, RESP_SLVERR);
    axi_read(8'h10, 32'h30, RESP_OKAY);
    axi_write(8'h14, 32'h9, RESP_OKAY);
    axi_read(8'h14, 32'h9, RESP_OKAY);
    $display("test registers done");
    axi_write(8'h00, 32'h3, RESP_OKAY);
    repeat (30) @(posedge tx_clk);
    for (int c = 0; c < NUM_CH; c++) flag_is(c, 1'b1, 0);
    cell_last(0, 48);
    cell_last(1, 9);
    repeat (10) @(posedge tx_clk);
    axi_read(8'h44, 32'h9, RESP_OKAY);
    $display("test cell mode done");
    axi_write(8'h00, 32'h2, RESP_OKAY);
    axi_write(8'h28, 32'h14, RESP_OKAY);
    axi_write(8'h38, 32'h0a, RESP_OKAY);
    repeat (30) @(posedge tx_clk);
    flag_is(2, 1'b1, 0);
    lyr.burst(2, 246, 0);
    flag_is(2, 1'b1, 2);
    lyr.burst(2, 1, 0);
    flag_is(2, 1'b0, 2);
    drain(2, 5);
    flag_is(2, 1'b0, 2);
    drain(2, 6);
    flag_is(2, 1'b1, 2);
    lyr.burst(2, 20, 0);
    flag_is(2, 1'b0, 2);
    flag_is(3, 1'b1, 0);
    repeat (10) @(posedge tx_clk);
    axi_read(8'h48, 32'h0, RESP_OKAY);
    axi_read(8'h4c, 32'h0001_0100, RESP_OKAY);
    $display("test packet mode done");
    for (int d = 0; d < 2; d++) begin
      axi_write(8'h00, 32'h50 + 32'(4 * d), RESP_OKAY);
      repeat (30) @(posedge tx_clk);
      lyr.poll(3'h5);
      for (int i = 1; i < 4; i++) begin
        @(negedge tx_clk);
        chk({31'h0, tx_frame_available_oe}, {31'h0, i == d + 1});
        @(posedge tx_clk);
      end
    end
    $display("test polling done");
    finish_test();
  end
endmodule

`default_nettype wire
